/* File: verilog/wdt_defines.vh */
// How it works
// - Eight-bit up-counter steps once per selected prescaled tick while counting is on.
// - Clock select 0 picks system clock over 8192, 1 picks subclock over 32.
// - Wrap from all ones to zero raises internal reset and sets overflow flag.
// - Overflow reset starts one base clock after the wrap and resets the chip.
// - Overflow reset is held for exactly 512 oscillator clock cycles.
// - Counter writes load the value; counting continues upward from it.
// - Counter writes land only while counter write enable is 1.
// - Counter runs while run bit is 1 and stops while it is 0.
// - Run bit sets on one write of guard 0, run 1, with status enable set.
// - Run bit clears on any reset or a write of guard 0, run 0.
// - Guard bits 7, 5, 3, 1 read 1, store nothing, qualify the bit below.
// - Bits 6 and 4 update only when their guard bit is written 0 together.
// - Bits 2 and 0 are writable only while status write enable holds 1.
// - Overflow flag clears only by the reset pin or a guarded write of 0.
// - Module stop bit 0 means module standby, 1 releases it; reset value 1.
// - Module stop written 0 while running is stored; standby waits for run clear.
// - Every reset loads zero into the counter.
// - Subactive counts only on subclock source; halt modes freeze counter and status.
`ifndef WDT_DEFINES_VH
`define WDT_DEFINES_VH

`define WDT_IDX_CSR 16'hffb2
`define WDT_IDX_CNT 16'hffb3
`define WDT_IDX_PORT3_MODE_CONTROL 16'hffca
`define WDT_IDX_CKSTP 16'hfffb

`define WDT_CSR_RESET 8'haa
`define WDT_CNT_RESET 8'h00
`define WDT_PORT3_MODE_CONTROL_RESET 8'h00
`define WDT_CKSTP_RESET 8'hff

`define WDT_B_CWEN_GUARD 7
`define WDT_B_CWEN 6
`define WDT_B_SWEN_GUARD 5
`define WDT_B_SWEN 4
`define WDT_B_RUN_GUARD 3
`define WDT_B_RUN 2
`define WDT_B_FLAG_GUARD 1
`define WDT_B_FLAG 0
`define WDT_B_CLK_SEL 5
`define WDT_B_MOD_STOP 2

`define WDT_CKSTP_RSVD 4'hf
`define WDT_CKSTP_LOW_W 4

`define WDT_SYS_DIV_W 13
`define WDT_SYS_DIV_LAST 13'h1fff
`define WDT_SUB_DIV_W 5
`define WDT_SUB_DIV_LAST 5'h1f
`define WDT_CNT_MAX 8'hff
`define WDT_CNT_ONE 8'h01

`define WDT_OSC_RESET_CYCLES 10'h200
`define WDT_OSC_CNT_W 10
`define WDT_OSC_CNT_ONE 10'h001
`define WDT_OSC_CNT_ZERO 10'h000

`define WDT_SYNC_SUB 0
`define WDT_SYNC_OSC 1

`endif

/* File: verilog/watchdog_timer_8bit.v */
`timescale 1ns/100ps
`include "wdt_defines.vh"

module watchdog_timer_8bit (
   input wire i_clk,
   input wire i_arst_n,
   input wire i_subclk,
   input wire i_oscclk,
   input wire i_mode_subactive,
   input wire i_mode_halted,
   input wire [15:0] i_avs_address,
   input wire i_avs_read,
   input wire i_avs_write,
   input wire [31:0] i_avs_writedata,
   input wire [3:0] i_avs_byteenable,
   output reg [31:0] o_avs_readdata,
   output wire o_avs_waitrequest,
   output reg o_wdt_reset,
   output wire o_module_standby
);

   // Pin synchronisers: bit 0 subclock, bit 1 oscillator clock
   reg [1:0] sync1_q;
   reg [1:0] sync2_q;
   reg [1:0] sync3_q;
   reg [1:0] level_q;
   reg [1:0] level_d;
   reg [1:0] level_prev_q;
   wire [1:0] rise;
   wire [1:0] pin_raw;

   assign pin_raw = {i_oscclk, i_subclk};

   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         sync1_q <= 2'h0;
         sync2_q <= 2'h0;
         sync3_q <= 2'h0;
         level_q <= 2'h0;
         level_prev_q <= 2'h0;
      end else begin
         sync1_q <= pin_raw;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         level_q <= level_d;
         level_prev_q <= level_q;
      end
   end

   // A level change counts only once stages two and three agree
   always @* begin
      level_d = level_q;
      if (sync2_q[`WDT_SYNC_SUB] == sync3_q[`WDT_SYNC_SUB]) begin
         level_d[`WDT_SYNC_SUB] = sync3_q[`WDT_SYNC_SUB];
      end
      if (sync2_q[`WDT_SYNC_OSC] == sync3_q[`WDT_SYNC_OSC]) begin
         level_d[`WDT_SYNC_OSC] = sync3_q[`WDT_SYNC_OSC];
      end
   end

   assign rise = level_q & ~level_prev_q;

   // Bus handshake: one wait cycle, then the access completes
   reg ack_q;
   wire req;
   wire wr_now;
   wire rd_now;
   wire lane0;
   wire [7:0] wdata;

   assign req = i_avs_read | i_avs_write;
   assign o_avs_waitrequest = req & ~ack_q;
   assign wr_now = i_avs_write & ack_q;
   assign rd_now = i_avs_read & ~ack_q;
   assign lane0 = i_avs_byteenable[0];
   assign wdata = i_avs_writedata[7:0];

   reg ack_d;

   always @* begin
      ack_d = req & ~ack_q;
   end

   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= ack_d;
      end
   end

   wire wr_csr;
   wire wr_cnt;
   wire wr_port3_mode_control;
   wire wr_ckstp;

   assign wr_csr = wr_now & lane0 & (i_avs_address == `WDT_IDX_CSR);
   assign wr_cnt = wr_now & lane0 & (i_avs_address == `WDT_IDX_CNT);
   assign wr_port3_mode_control = wr_now & lane0 & (i_avs_address == `WDT_IDX_PORT3_MODE_CONTROL);
   assign wr_ckstp = wr_now & lane0 & (i_avs_address == `WDT_IDX_CKSTP);

   // Registers
   reg cwen_q;
   reg swen_q;
   reg run_q;
   reg flag_q;
   reg [7:0] cnt_q;
   reg [7:0] cnt_d;
   reg [7:0] port3_mode_control_q;
   reg [3:0] ckstp_q;
   reg ovf_pend_q;
   reg [`WDT_OSC_CNT_W-1:0] osc_cnt_q;

   wire clk_sel;
   wire standby_eff;
   wire frozen;
   wire tick;
   wire cnt_step;
   wire overflow;
   wire int_rst;

   assign clk_sel = port3_mode_control_q[`WDT_B_CLK_SEL];
   // A stored stop bit only bites once the watchdog is no longer running
   assign standby_eff = ~ckstp_q[`WDT_B_MOD_STOP] & ~run_q;
   assign o_module_standby = standby_eff;
   // Halt modes freeze counter and status; subactive needs the subclock source
   assign frozen = i_mode_halted | standby_eff | (i_mode_subactive & ~clk_sel);
   // The whole chip is in reset while the pulse is out, this block too except the flag
   assign int_rst = o_wdt_reset;

   // Prescalers
   reg [`WDT_SYS_DIV_W-1:0] sys_div_q;
   reg [`WDT_SUB_DIV_W-1:0] sub_div_q;
   wire sys_tick;
   wire sub_tick;

   reg [`WDT_SYS_DIV_W-1:0] sys_div_d;
   reg [`WDT_SUB_DIV_W-1:0] sub_div_d;

   // Prescalers run free, so starting the counter never waits on them
   always @* begin
      sys_div_d = sys_div_q + 1'b1;
      sub_div_d = sub_div_q;
      if (rise[`WDT_SYNC_SUB]) begin
         sub_div_d = sub_div_q + 1'b1;
      end
      if (int_rst) begin
         sys_div_d = {`WDT_SYS_DIV_W{1'b0}};
         sub_div_d = {`WDT_SUB_DIV_W{1'b0}};
      end
   end

   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         sys_div_q <= {`WDT_SYS_DIV_W{1'b0}};
         sub_div_q <= {`WDT_SUB_DIV_W{1'b0}};
      end else begin
         sys_div_q <= sys_div_d;
         sub_div_q <= sub_div_d;
      end
   end

   assign sys_tick = (sys_div_q == `WDT_SYS_DIV_LAST);
   assign sub_tick = rise[`WDT_SYNC_SUB] & (sub_div_q == `WDT_SUB_DIV_LAST);
   assign tick = clk_sel ? sub_tick : sys_tick;

   wire wr_cnt_ok;
   wire cnt_at_max;

   assign wr_cnt_ok = wr_cnt & cwen_q & ~frozen;
   assign cnt_at_max = (cnt_q == `WDT_CNT_MAX);
   assign cnt_step = tick & run_q & ~frozen;
   // A counter write in the same cycle discards the step and any wrap
   assign overflow = cnt_step & ~wr_cnt_ok & cnt_at_max;

   always @* begin
      cnt_d = cnt_q;
      if (wr_cnt_ok) begin
         cnt_d = wdata;
      end else if (cnt_step) begin
         cnt_d = cnt_q + `WDT_CNT_ONE;
      end
   end

   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cnt_q <= `WDT_CNT_RESET;
      end else if (int_rst) begin
         cnt_q <= `WDT_CNT_RESET;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   // Control and status bits; guard bits are never stored
   localparam [7:0] csr_rst_val = `WDT_CSR_RESET;
   localparam [7:0] ckstp_rst_val = `WDT_CKSTP_RESET;

   wire csr_wr_ok;
   reg cwen_d;
   reg swen_d;
   reg run_d;
   reg flag_d;
   reg [7:0] port3_mode_control_d;
   reg [3:0] ckstp_d;

   assign csr_wr_ok = wr_csr & ~frozen;

   always @* begin
      cwen_d = cwen_q;
      swen_d = swen_q;
      run_d = run_q;
      if (int_rst) begin
         cwen_d = csr_rst_val[`WDT_B_CWEN];
         swen_d = csr_rst_val[`WDT_B_SWEN];
         run_d = csr_rst_val[`WDT_B_RUN];
      end else if (csr_wr_ok) begin
         if (!wdata[`WDT_B_CWEN_GUARD]) begin
            cwen_d = wdata[`WDT_B_CWEN];
         end
         if (!wdata[`WDT_B_SWEN_GUARD]) begin
            swen_d = wdata[`WDT_B_SWEN];
         end
         // Uses the enable held before this write, never the one written now
         if (swen_q && !wdata[`WDT_B_RUN_GUARD]) begin
            run_d = wdata[`WDT_B_RUN];
         end
      end
   end

   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cwen_q <= csr_rst_val[`WDT_B_CWEN];
         swen_q <= csr_rst_val[`WDT_B_SWEN];
         run_q <= csr_rst_val[`WDT_B_RUN];
      end else begin
         cwen_q <= cwen_d;
         swen_q <= swen_d;
         run_q <= run_d;
      end
   end

   // Only the reset pin clears the flag asynchronously; the wrap sets it
   // A set in the same cycle as a clear wins
   always @* begin
      flag_d = flag_q;
      if (overflow) begin
         flag_d = 1'b1;
      end else if (csr_wr_ok && swen_q && !wdata[`WDT_B_FLAG_GUARD]
                   && !wdata[`WDT_B_FLAG]) begin
         flag_d = 1'b0;
      end
   end

   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         flag_q <= csr_rst_val[`WDT_B_FLAG];
      end else begin
         flag_q <= flag_d;
      end
   end

   // Clock source select lives in the port mode register; a change while
   // running is not blocked, software must stop the watchdog first
   always @* begin
      port3_mode_control_d = port3_mode_control_q;
      ckstp_d = ckstp_q;
      if (int_rst) begin
         port3_mode_control_d = `WDT_PORT3_MODE_CONTROL_RESET;
         ckstp_d = ckstp_rst_val[`WDT_CKSTP_LOW_W-1:0];
      end else begin
         if (wr_port3_mode_control) begin
            port3_mode_control_d = wdata;
         end
         if (wr_ckstp) begin
            ckstp_d = wdata[`WDT_CKSTP_LOW_W-1:0];
         end
      end
   end

   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         port3_mode_control_q <= `WDT_PORT3_MODE_CONTROL_RESET;
         ckstp_q <= ckstp_rst_val[`WDT_CKSTP_LOW_W-1:0];
      end else begin
         port3_mode_control_q <= port3_mode_control_d;
         ckstp_q <= ckstp_d;
      end
   end

   // Reset pulse: one base clock after the wrap, then 512 oscillator edges
   reg ovf_pend_d;
   reg wdt_reset_d;
   reg [`WDT_OSC_CNT_W-1:0] osc_cnt_d;
   wire osc_last;
   wire pulse_start;
   wire pulse_step;

   assign osc_last = (osc_cnt_q == `WDT_OSC_RESET_CYCLES - `WDT_OSC_CNT_ONE);
   assign pulse_start = ovf_pend_q & ~o_wdt_reset;
   assign pulse_step = o_wdt_reset & rise[`WDT_SYNC_OSC];

   // The edge count restarts when a new pulse begins and clears after the last edge
   always @* begin
      ovf_pend_d = overflow;
      wdt_reset_d = o_wdt_reset;
      osc_cnt_d = osc_cnt_q;
      if (pulse_start) begin
         wdt_reset_d = 1'b1;
         osc_cnt_d = `WDT_OSC_CNT_ZERO;
      end else if (pulse_step) begin
         if (osc_last) begin
            wdt_reset_d = 1'b0;
            osc_cnt_d = `WDT_OSC_CNT_ZERO;
         end else begin
            osc_cnt_d = osc_cnt_q + `WDT_OSC_CNT_ONE;
         end
      end
   end

   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ovf_pend_q <= 1'b0;
         o_wdt_reset <= 1'b0;
         osc_cnt_q <= `WDT_OSC_CNT_ZERO;
      end else begin
         ovf_pend_q <= ovf_pend_d;
         o_wdt_reset <= wdt_reset_d;
         osc_cnt_q <= osc_cnt_d;
      end
   end

   // Read data; guard bits and reserved bits read as one
   reg [7:0] rd_byte;

   always @* begin
      rd_byte = 8'h00;
      case (i_avs_address)
         `WDT_IDX_CSR: begin
            rd_byte = {1'b1, cwen_q, 1'b1, swen_q, 1'b1, run_q, 1'b1, flag_q};
         end
         `WDT_IDX_CNT: begin
            rd_byte = cnt_q;
         end
         `WDT_IDX_PORT3_MODE_CONTROL: begin
            rd_byte = port3_mode_control_q;
         end
         `WDT_IDX_CKSTP: begin
            rd_byte = {`WDT_CKSTP_RSVD, ckstp_q};
         end
         default: begin
            rd_byte = 8'h00;
         end
      endcase
   end

   reg [31:0] rdata_d;

   always @* begin
      rdata_d = o_avs_readdata;
      if (rd_now) begin
         rdata_d = {24'h00_0000, rd_byte};
      end
   end

   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_avs_readdata <= 32'h0000_0000;
      end else begin
         o_avs_readdata <= rdata_d;
      end
   end

endmodule

/* File: test/watchdog_timer_8bit_asserts.sv */
`timescale 1ns/100ps
module wdt_checker (
   input wire i_clk,
   input wire i_arst_n,
   input wire i_oscclk,
   input wire [15:0] i_avs_address,
   input wire i_avs_read,
   input wire i_avs_write,
   input wire [31:0] o_avs_readdata,
   input wire o_avs_waitrequest,
   input wire o_wdt_reset,
   input wire o_module_standby
);
   logic osc_q;
   logic [11:0] osc_n;
   wire rd_first = i_avs_read & o_avs_waitrequest;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);
   // Raw oscillator rises while the pulse is high; sync lag needs slack
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         osc_q <= 1'b0;
         osc_n <= 12'h000;
      end else begin
         osc_q <= i_oscclk;
         if (!o_wdt_reset)
            osc_n <= 12'h000;
         else if (i_oscclk & ~osc_q)
            osc_n <= osc_n + 12'h001;
      end
   end
   wait_one_a: assert property ($rose(i_avs_read | i_avs_write) |->
      o_avs_waitrequest ##1 !o_avs_waitrequest) else $error("wait length");
   idle_wait_a: assert property (!(i_avs_read | i_avs_write) |-> !o_avs_waitrequest)
      else $error("idle wait");
   rd_hold_a: assert property (!i_avs_read |=> $stable(o_avs_readdata)) else $error("rd hold");
   hi_zero_a: assert property (o_avs_readdata[31:8] == 24'h0) else $error("high bits");
   unmapped_a: assert property (rd_first && i_avs_address == 16'hffb0 |=>
      o_avs_readdata == 32'h0) else $error("unmapped");
   guard_read_a: assert property (rd_first && i_avs_address == 16'hffb2 |=>
      (o_avs_readdata & 32'haa) == 32'haa) else $error("guard bits");
   stop_rsvd_a: assert property (rd_first && i_avs_address == 16'hfffb |=>
      o_avs_readdata[7:4] == 4'hf) else $error("stop upper bits");
   pulse_len_a: assert property ($fell(o_wdt_reset) |->
      osc_n >= 12'd509 && osc_n <= 12'd515) else $error("pulse length");
   pulse_min_a: assert property (o_wdt_reset && osc_n < 12'd500 |=> o_wdt_reset)
      else $error("pulse short");
   stby_rst_a: assert property (o_wdt_reset |=> !o_module_standby)
      else $error("standby in reset");
   cnt_rst_a: assert property (o_wdt_reset [*2] ##0 rd_first &&
      i_avs_address == 16'hffb3 |=> o_avs_readdata == 32'h0) else $error("count reset");
   flag_keep_a: assert property (o_wdt_reset [*2] ##0 rd_first &&
      i_avs_address == 16'hffb2 |=> o_avs_readdata == 32'hab) else $error("flag kept");
   cover property ($rose(o_wdt_reset));
   cover property ($fell(o_module_standby));
   cover property (rd_first && i_avs_address == 16'hffb3);
endmodule

bind watchdog_timer_8bit wdt_checker chk (.i_clk, .i_arst_n, .i_oscclk, .i_avs_address,
   .i_avs_read, .i_avs_write, .o_avs_readdata, .o_avs_waitrequest, .o_wdt_reset,
   .o_module_standby);

/* File: test/watchdog_timer_8bit_tb.sv */
`timescale 1ns/100ps
module watchdog_timer_8bit_tb;
   logic i_clk, i_arst_n, i_subclk, i_oscclk, i_mode_subactive, i_mode_halted;
   logic i_avs_read, i_avs_write, sb;
   logic [15:0] i_avs_address;
   logic [31:0] i_avs_writedata;
   logic [3:0] i_avs_byteenable;
   wire [31:0] o_avs_readdata;
   wire o_avs_waitrequest, o_wdt_reset, o_module_standby;
   logic [1:0] ph;
   logic [7:0] q, a;
   logic [32:0] rows [0:11];
   int err_total, samples_checked, n;
   realtime t_rise, t_fall;
   watchdog_timer_8bit uut (.i_clk, .i_arst_n, .i_subclk, .i_oscclk, .i_mode_subactive,
      .i_mode_halted, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
      .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .o_wdt_reset,
      .o_module_standby);
   initial begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end
   // Quarter-rate sub and osc clocks keep the overflow runs short
   always @(posedge i_clk) begin
      ph <= ph + 2'h1;
      i_subclk <= ph[1];
      i_oscclk <= ph[1];
   end
   always @(posedge o_wdt_reset) t_rise = $realtime;
   always @(negedge o_wdt_reset) t_fall = $realtime;
   task automatic chk(input [7:0] seen, input [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic final_report;
      $display("checks=%0d errors=%0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // Request held until waitrequest is seen low at a rising edge
   task automatic bus(input rd, input [15:0] ad, input [7:0] d);
      i_avs_address <= ad;
      i_avs_writedata <= {24'h0, d};
      i_avs_read <= rd;
      i_avs_write <= !rd;
      n = 0;
      @(posedge i_clk);
      while (o_avs_waitrequest !== 1'b0 && n < 20) begin
         @(posedge i_clk);
         n++;
      end
      if (n >= 20) err_total++;
      q = o_avs_readdata[7:0];
      sb = o_module_standby;
      i_avs_read <= 1'b0;
      i_avs_write <= 1'b0;
      @(posedge i_clk);
   endtask
   task automatic wr(input [15:0] ad, input [7:0] d);
      bus(1'b0, ad, d);
   endtask
   task automatic rd(input [15:0] ad, input [7:0] e);
      bus(1'b1, ad, 8'h00);
      chk(q, e);
   endtask
   task automatic wait_rst(input v, input int lim);
      n = 0;
      while (o_wdt_reset !== v && n < lim) begin
         @(negedge i_clk);
         n++;
      end
      chk({7'h0, o_wdt_reset}, {7'h0, v});
      @(posedge i_clk);
   endtask
   initial begin
      {i_arst_n, i_mode_subactive, i_mode_halted, i_avs_read, i_avs_write} = 5'h00;
      {i_subclk, i_oscclk, ph, i_avs_address, i_avs_writedata} = 0;
      i_avs_byteenable = 4'h1;
      err_total = 0;
      samples_checked = 0;
      rows = '{{16'hffb2, 8'hff, 8'haa, 1'b0}, {16'hffb2, 8'hf6, 8'haa, 1'b0},
         {16'hffb2, 8'hdf, 8'hba, 1'b0}, {16'hffb2, 8'h7f, 8'hfa, 1'b0},
         {16'hffb3, 8'h12, 8'h12, 1'b0}, {16'hffb2, 8'h3f, 8'hba, 1'b0},
         {16'hffb3, 8'h34, 8'h12, 1'b0}, {16'hffb0, 8'h55, 8'h00, 1'b0},
         {16'hfffb, 8'hfb, 8'hfb, 1'b1}, {16'hffb2, 8'h7f, 8'hba, 1'b1},
         {16'hfffb, 8'hff, 8'hff, 1'b0}, {16'hffca, 8'h20, 8'h20, 1'b0}};
      repeat (6) @(posedge i_clk);
      i_arst_n <= 1'b1;
      @(posedge i_clk);
      foreach (rows[i]) begin
         wr(rows[i][32:17], rows[i][16:9]);
         rd(rows[i][32:17], rows[i][8:1]);
         chk({7'h0, sb}, {7'h0, rows[i][0]});
      end
      wr(16'hffb2, 8'h7f);
      wr(16'hffb3, 8'hfd);
      wr(16'hffb2, 8'hf6);
      rd(16'hffb2, 8'hfe);
      wr(16'hfffb, 8'hfb);
      rd(16'hfffb, 8'hfb);
      chk({7'h0, sb}, 8'h00);
      wait_rst(1'b1, 1000);
      rd(16'hffb3, 8'h00);
      rd(16'hffb2, 8'hab);
      wait_rst(1'b0, 3000);
      chk(8'(t_fall - t_rise > 81.5e3 && t_fall - t_rise < 82.4e3), 8'h01);
      wr(16'hffb2, 8'hdf);
      wr(16'hffb2, 8'hfc);
      rd(16'hffb2, 8'hba);
      wr(16'hffca, 8'h20);
      wr(16'hffb2, 8'h7f);
      wr(16'hffb3, 8'h40);
      wr(16'hffb2, 8'hf6);
      wr(16'hfffb, 8'hfb);
      repeat (300) @(posedge i_clk);
      bus(1'b1, 16'hffb3, 8'h00);
      chk(8'(q > 8'h40 && q < 8'h45), 8'h01);
      wr(16'hffb2, 8'hf2);
      rd(16'hffb2, 8'hfa);
      chk({7'h0, sb}, 8'h01);
      bus(1'b1, 16'hffb3, 8'h00);
      a = q;
      repeat (300) @(posedge i_clk);
      rd(16'hffb3, a);
      wr(16'hfffb, 8'hff);
      wr(16'hffb3, 8'h80);
      wr(16'hffb2, 8'hf6);
      i_mode_halted <= 1'b1;
      bus(1'b1, 16'hffb3, 8'h00);
      a = q;
      repeat (400) @(posedge i_clk);
      rd(16'hffb3, a);
      i_mode_halted <= 1'b0;
      i_mode_subactive <= 1'b1;
      wr(16'hffb3, 8'hff);
      wait_rst(1'b1, 200);
      i_mode_subactive <= 1'b0;
      wait_rst(1'b0, 3000);
      i_arst_n <= 1'b0;
      @(posedge i_clk);
      i_arst_n <= 1'b1;
      @(posedge i_clk);
      rd(16'hffb2, 8'haa);
      rd(16'hffb3, 8'h00);
      rd(16'hffca, 8'h00);
      rd(16'hfffb, 8'hff);
      wr(16'hffb2, 8'hdf);
      wr(16'hffb2, 8'hf6);
      repeat (8300) @(posedge i_clk);
      wr(16'hffb2, 8'hf2);
      bus(1'b1, 16'hffb3, 8'h00);
      chk(8'(q == 8'h01 || q == 8'h02), 8'h01);
      final_report;
   end
   initial begin
      #2000000;
      err_total++;
      final_report;
   end
endmodule
